// file: pkg/qep_pkg.sv
package qep_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [5:0] IDX_CONFIG = 6'h38;
   localparam logic [5:0] IDX_POSITION = 6'h39;
   localparam logic [5:0] IDX_SCALE = 6'h3A;
   localparam logic [5:0] IDX_FLAGS = 6'h3B;
   localparam logic [5:0] IDX_LATCH = 6'h3C;
   localparam logic [5:0] IDX_THRESH = 6'h3D;
   localparam logic [5:0] IDX_MASK = 6'h3E;
   localparam int ADDR_W = 8;
   localparam logic [1:0] ADDR_LSB = 2'h0;

   localparam int CFG_W = 11;
   localparam int THRESH_W = 20;
   localparam int FLAG_W = 2;

   // encoder_config fields
   localparam int CFG_POL_A = 0;
   localparam int CFG_POL_B = 1;
   localparam int CFG_POL_N = 2;
   localparam int CFG_SKIP_QUAL = 3;
   localparam int CFG_CLR_CONT = 4;
   localparam int CFG_CLR_ONCE = 5;
   localparam int CFG_SENS_LO = 6;
   localparam int CFG_SENS_HI = 7;
   localparam int CFG_CLR_POS = 8;
   localparam int CFG_LATCH_RAMP = 9;
   localparam int CFG_SEL_DEC = 10;

   // Sensitivity field {inactive-going, active-going}
   localparam logic [1:0] SENS_LEVEL = 2'h0;
   localparam logic [1:0] SENS_RISE = 2'h1;
   localparam logic [1:0] SENS_FALL = 2'h2;
   localparam logic [1:0] SENS_BOTH = 2'h3;

   // encoder_event_flags fields
   localparam int FLAG_INDEX = 0;
   localparam int FLAG_DRIFT = 1;

   // Scale constant: signed integer in the upper half, fraction below
   localparam int FRAC_W = 16;
   localparam logic [FRAC_W:0] FRAC_MOD_BIN = 17'h10000;
   localparam logic [FRAC_W:0] FRAC_MOD_DEC = 17'h02710;

   localparam logic [CFG_W-1:0] CONFIG_RESET = 11'h000;
   localparam logic [31:0] SCALE_RESET = 32'h0001_0000;
   localparam logic [THRESH_W-1:0] THRESH_RESET = 20'h00000;
   localparam logic [FLAG_W-1:0] MASK_RESET = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: core/qep_quad_decoder.sv
`timescale 1ns/1ps
module qep_quad_decoder (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic encA,
   input wire logic encB,
   input wire logic encN,
   output logic levelA,
   output logic levelB,
   output logic levelN,
   output logic step,
   output logic stepUp
);
   logic [2:0] syncFirst_reg;
   logic [2:0] syncSecond_reg;
   logic prevA_reg;
   logic prevB_reg;
   logic changeA;
   logic changeB;

   // Two-stage synchroniser per pin
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         syncFirst_reg <= 3'h0;
         syncSecond_reg <= 3'h0;
      end else begin
         syncFirst_reg <= {encN, encB, encA};
         syncSecond_reg <= syncFirst_reg;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prevA_reg <= 1'b0;
         prevB_reg <= 1'b0;
      end else begin
         prevA_reg <= syncSecond_reg[0];
         prevB_reg <= syncSecond_reg[1];
      end
   end

   assign levelA = syncSecond_reg[0];
   assign levelB = syncSecond_reg[1];
   assign levelN = syncSecond_reg[2];
   assign changeA = prevA_reg ^ levelA;
   assign changeB = prevB_reg ^ levelB;
   // One channel moving is a step; both at once is a lost state, ignored
   assign step = changeA ^ changeB;
   assign stepUp = ~(prevA_reg ^ levelB);
endmodule

// file: core/qep_unit.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// - Signed 32-bit position, readable and writable
// - Fraction binary or ten-thousandths, per config
// - Two flags, index and drift, write-one-clear
// - Drift flag stays while drift persists
// - Flags, each gated by its mask bit, ORed onto interrupt output
// - Drift flag when position gap exceeds threshold
// - Zero threshold disables drift checking
// - Eleven-bit read-write encoder configuration
// - Index latches position, optionally clears it
// - Index qualified by A/B levels, N polarity
// - Index sensitivity: level, rise, fall, both
// - Index action once after write or continuous
module qep_unit (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [qep_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [qep_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic encA,
   input wire logic encB,
   input wire logic encN,
   input wire logic [31:0] rampActualPosition,
   output logic irq
);
   localparam int AW = qep_pkg::ADDR_W;
   localparam logic [AW-1:0] A_CONFIG = {qep_pkg::IDX_CONFIG, 2'h0};
   localparam logic [AW-1:0] A_POS = {qep_pkg::IDX_POSITION, 2'h0};
   localparam logic [AW-1:0] A_SCALE = {qep_pkg::IDX_SCALE, 2'h0};
   localparam logic [AW-1:0] A_FLAGS = {qep_pkg::IDX_FLAGS, 2'h0};
   localparam logic [AW-1:0] A_LATCH = {qep_pkg::IDX_LATCH, 2'h0};
   localparam logic [AW-1:0] A_THRESH = {qep_pkg::IDX_THRESH, 2'h0};
   localparam logic [AW-1:0] A_MASK = {qep_pkg::IDX_MASK, 2'h0};

   logic [AW-1:0] awAddr_reg;
   logic awHeld_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic wHeld_reg;
   logic wrEn;
   logic wrHit;
   logic [31:0] wrMerged;
   logic rdTake;

   logic [qep_pkg::CFG_W-1:0] config_reg;
   logic [31:0] pos_reg;
   logic [qep_pkg::FRAC_W-1:0] frac_reg;
   logic [31:0] scale_reg;
   logic [qep_pkg::FLAG_W-1:0] flags_reg;
   logic [qep_pkg::FLAG_W-1:0] mask_reg;
   logic [31:0] latch_reg;
   logic [qep_pkg::THRESH_W-1:0] thresh_reg;
   logic onceArmed_reg;
   logic nQualPrev_reg;

   logic levelA;
   logic levelB;
   logic levelN;
   logic step;
   logic stepUp;
   logic nActive;
   logic nQual;
   logic nHit;
   logic idxAction;
   logic posWrite;
   logic cfgWrite;
   logic [31:0] posStep;
   logic [qep_pkg::FRAC_W-1:0] fracStep;
   logic [qep_pkg::FRAC_W:0] fracMod;
   logic [32:0] gap;
   logic [32:0] gapMag;
   logic driftCond;
   logic rdFlags;
   logic wrFlags;

   function automatic logic [31:0] mergeBytes(
      input logic [31:0] old,
      input logic [31:0] nw,
      input logic [3:0] strb
   );
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   qep_quad_decoder decoder (
      .mclk(mclk),
      .rstn(rstn),
      .encA(encA),
      .encB(encB),
      .encN(encN),
      .levelA(levelA),
      .levelB(levelB),
      .levelN(levelN),
      .step(step),
      .stepUp(stepUp)
   );

   // Write channel: address and data taken in either order
   assign awready = !awHeld_reg && !bvalid;
   assign wready = !wHeld_reg && !bvalid;
   assign wrEn = awHeld_reg && wHeld_reg && !bvalid;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         awHeld_reg <= 1'b0;
         awAddr_reg <= '0;
      end else if (awvalid && awready) begin
         awHeld_reg <= 1'b1;
         awAddr_reg <= awaddr;
      end else if (wrEn) begin
         awHeld_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wHeld_reg <= 1'b0;
         wData_reg <= '0;
         wStrb_reg <= 4'h0;
      end else if (wvalid && wready) begin
         wHeld_reg <= 1'b1;
         wData_reg <= wdata;
         wStrb_reg <= wstrb;
      end else if (wrEn) begin
         wHeld_reg <= 1'b0;
      end
   end

   always_comb begin
      unique case (awAddr_reg)
         A_CONFIG: wrMerged = mergeBytes(32'(config_reg), wData_reg,
            wStrb_reg);
         A_POS: wrMerged = mergeBytes(pos_reg, wData_reg, wStrb_reg);
         A_SCALE: wrMerged = mergeBytes(scale_reg, wData_reg, wStrb_reg);
         A_THRESH: wrMerged = mergeBytes(32'(thresh_reg), wData_reg,
            wStrb_reg);
         A_MASK: wrMerged = mergeBytes(32'(mask_reg), wData_reg,
            wStrb_reg);
         default: wrMerged = wData_reg & {{8{wStrb_reg[3]}},
            {8{wStrb_reg[2]}}, {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
      endcase
   end

   assign wrHit = (awAddr_reg == A_CONFIG) || (awAddr_reg == A_POS)
      || (awAddr_reg == A_SCALE) || (awAddr_reg == A_FLAGS)
      || (awAddr_reg == A_LATCH) || (awAddr_reg == A_THRESH)
      || (awAddr_reg == A_MASK);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bvalid <= 1'b0;
         bresp <= qep_pkg::RESP_OKAY;
      end else if (wrEn) begin
         bvalid <= 1'b1;
         bresp <= wrHit ? qep_pkg::RESP_OKAY : qep_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   assign posWrite = wrEn && (awAddr_reg == A_POS);
   assign cfgWrite = wrEn && (awAddr_reg == A_CONFIG);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         config_reg <= qep_pkg::CONFIG_RESET;
      end else if (cfgWrite) begin
         config_reg <= wrMerged[qep_pkg::CFG_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         scale_reg <= qep_pkg::SCALE_RESET;
         thresh_reg <= qep_pkg::THRESH_RESET;
         mask_reg <= qep_pkg::MASK_RESET;
      end else if (wrEn) begin
         if (awAddr_reg == A_SCALE) begin
            scale_reg <= wrMerged;
         end
         if (awAddr_reg == A_THRESH) begin
            thresh_reg <= wrMerged[qep_pkg::THRESH_W-1:0];
         end
         if (awAddr_reg == A_MASK) begin
            mask_reg <= wrMerged[qep_pkg::FLAG_W-1:0];
         end
      end
   end

   // Read channel; scale and threshold are write-only and read zero
   assign arready = !rvalid;
   assign rdTake = arvalid && arready;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= qep_pkg::RESP_OKAY;
      end else if (rdTake) begin
         rvalid <= 1'b1;
         rresp <= qep_pkg::RESP_OKAY;
         unique case (araddr)
            A_CONFIG: rdata <= 32'(config_reg);
            A_POS: rdata <= pos_reg;
            A_FLAGS: rdata <= 32'(flags_reg);
            A_LATCH: rdata <= latch_reg;
            A_MASK: rdata <= 32'(mask_reg);
            A_SCALE, A_THRESH: rdata <= '0;
            default: begin
               rdata <= '0;
               rresp <= qep_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // Scaled step: integer part signed, fraction carries at the modulus
   always_comb begin
      logic [qep_pkg::FRAC_W:0] sum;
      logic [qep_pkg::FRAC_W:0] cFrac;
      logic [31:0] cInt;
      sum = '0;
      cFrac = {1'b0, scale_reg[qep_pkg::FRAC_W-1:0]};
      cInt = {{16{scale_reg[31]}}, scale_reg[31:qep_pkg::FRAC_W]};
      fracMod = config_reg[qep_pkg::CFG_SEL_DEC] ? qep_pkg::FRAC_MOD_DEC
         : qep_pkg::FRAC_MOD_BIN;
      if (stepUp) begin
         sum = {1'b0, frac_reg} + cFrac;
         if (sum >= fracMod) begin
            sum = sum - fracMod;
            posStep = pos_reg + cInt + 32'h0000_0001;
         end else begin
            posStep = pos_reg + cInt;
         end
      end else begin
         sum = {1'b0, frac_reg} - cFrac;
         if ({1'b0, frac_reg} < cFrac) begin
            sum = sum + fracMod;
            posStep = pos_reg - cInt - 32'h0000_0001;
         end else begin
            posStep = pos_reg - cInt;
         end
      end
      fracStep = sum[qep_pkg::FRAC_W-1:0];
   end

   // Index qualification and sensitivity
   assign nActive = levelN ~^ config_reg[qep_pkg::CFG_POL_N];
   assign nQual = nActive && (config_reg[qep_pkg::CFG_SKIP_QUAL]
      || ((levelA == config_reg[qep_pkg::CFG_POL_A])
      && (levelB == config_reg[qep_pkg::CFG_POL_B])));

   always_comb begin
      unique case (config_reg[qep_pkg::CFG_SENS_HI:qep_pkg::CFG_SENS_LO])
         qep_pkg::SENS_LEVEL: nHit = nQual;
         qep_pkg::SENS_RISE: nHit = nQual && !nQualPrev_reg;
         qep_pkg::SENS_FALL: nHit = !nQual && nQualPrev_reg;
         qep_pkg::SENS_BOTH: nHit = nQual ^ nQualPrev_reg;
      endcase
   end

   assign idxAction = nHit && (config_reg[qep_pkg::CFG_CLR_CONT]
      || onceArmed_reg);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         nQualPrev_reg <= 1'b0;
      end else begin
         nQualPrev_reg <= nQual;
      end
   end

   // A new write re-arms even if an action lands in the same cycle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         onceArmed_reg <= 1'b0;
      end else if (cfgWrite) begin
         onceArmed_reg <= wrMerged[qep_pkg::CFG_CLR_ONCE];
      end else if (idxAction) begin
         onceArmed_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         latch_reg <= '0;
      end else if (idxAction) begin
         latch_reg <= pos_reg;
      end
   end

   // Software write beats index clear, which beats a step
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pos_reg <= '0;
         frac_reg <= '0;
      end else if (posWrite) begin
         pos_reg <= wrMerged;
         frac_reg <= '0;
      end else if (idxAction && config_reg[qep_pkg::CFG_CLR_POS]) begin
         pos_reg <= '0;
         frac_reg <= '0;
      end else if (step) begin
         pos_reg <= posStep;
         frac_reg <= fracStep;
      end
   end

   // Drift check on the full 33-bit difference, so no wrap
   assign gap = {pos_reg[31], pos_reg}
      - {rampActualPosition[31], rampActualPosition};
   assign gapMag = gap[32] ? (33'h0 - gap) : gap;
   assign driftCond = (thresh_reg != '0)
      && (gapMag > 33'(thresh_reg));

   // Flags: set wins over write-one-clear and over read-clear
   assign rdFlags = rdTake && (araddr == A_FLAGS);
   assign wrFlags = wrEn && (awAddr_reg == A_FLAGS);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flags_reg <= '0;
      end else begin
         if (nHit) begin
            flags_reg[qep_pkg::FLAG_INDEX] <= 1'b1;
         end else if (rdFlags || (wrFlags
            && wrMerged[qep_pkg::FLAG_INDEX])) begin
            flags_reg[qep_pkg::FLAG_INDEX] <= 1'b0;
         end
         if (driftCond) begin
            flags_reg[qep_pkg::FLAG_DRIFT] <= 1'b1;
         end else if (rdFlags || (wrFlags
            && wrMerged[qep_pkg::FLAG_DRIFT])) begin
            flags_reg[qep_pkg::FLAG_DRIFT] <= 1'b0;
         end
      end
   end

   assign irq = |(flags_reg & mask_reg);

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   irq_from_flags_a: assert property (
      (flags_reg != '0 && mask_reg == qep_pkg::MASK_RESET) |-> irq)
      else $error("interrupt low with a flag set");
   drift_sets_a: assert property (
      driftCond |=> flags_reg[qep_pkg::FLAG_DRIFT])
      else $error("drift flag not set");
   drift_persists_a: assert property (
      (flags_reg[qep_pkg::FLAG_DRIFT] && driftCond)
      |=> flags_reg[qep_pkg::FLAG_DRIFT])
      else $error("drift flag cleared while drift persists");
   zero_thresh_a: assert property (
      (thresh_reg == '0 && !flags_reg[qep_pkg::FLAG_DRIFT]
      && !wrEn) |=> !flags_reg[qep_pkg::FLAG_DRIFT])
      else $error("drift flag with zero threshold");
   index_latch_a: assert property (
      idxAction |=> latch_reg == $past(pos_reg))
      else $error("index did not latch position");
   index_clear_a: assert property (
      (idxAction && config_reg[qep_pkg::CFG_CLR_POS] && !posWrite)
      |=> pos_reg == '0)
      else $error("index did not clear position");
   once_disarm_a: assert property (
      (idxAction && !cfgWrite) |=> !onceArmed_reg)
      else $error("single index action stayed armed");
   pos_write_a: assert property (
      posWrite |=> pos_reg == $past(wrMerged))
      else $error("position write lost");
   unit_step_a: assert property (
      (step && stepUp && !posWrite && !idxAction
      && scale_reg == qep_pkg::SCALE_RESET)
      |=> pos_reg == $past(pos_reg) + 32'h0000_0001)
      else $error("unit scale step not one count");
   write_resp_a: assert property (
      wrEn |=> bvalid && bresp == ($past(wrHit) ? qep_pkg::RESP_OKAY
      : qep_pkg::RESP_SLVERR))
      else $error("write response missing");

   index_seen_c: cover property (idxAction ##1 pos_reg == '0);
   drift_seen_c: cover property ($rose(flags_reg[qep_pkg::FLAG_DRIFT]));
   flag_read_c: cover property (rdTake && araddr == A_FLAGS && irq);
endmodule

// file: verification/qep_enc_model.sv
`timescale 1ns/1ps
module qep_enc_model (
   input wire logic mclk,
   input wire logic stepReq,
   input wire logic stepDown,
   input wire logic indexLevel,
   output logic encA,
   output logic encB,
   output logic encN
);
   logic [1:0] phase = 2'h0;
   // Gray order 00,10,11,01 is forward; only one channel moves per step
   always @(posedge mclk) begin
      if (stepReq) begin
         phase <= stepDown ? phase - 2'h1 : phase + 2'h1;
      end
   end
   assign encA = phase[0] ^ phase[1];
   assign encB = phase[1];
   assign encN = indexLevel;
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic mclk;
   logic rstn;
   logic [qep_pkg::ADDR_W-1:0] awaddr;
   logic [qep_pkg::ADDR_W-1:0] araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, val, rampActualPosition;
   logic stepReq, stepDown, indexLevel;
   wire logic encA, encB, encN;
   logic [31:0] posv [2] = '{32'h8000_0000, 32'h7FFF_FFFF};
   logic [3:0] onRise = 4'hB;
   logic [3:0] onFall = 4'hD;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   int ph = 0;

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   qep_unit u_dut (.mclk(mclk), .rstn(rstn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .encA(encA), .encB(encB), .encN(encN),
      .rampActualPosition(rampActualPosition), .irq(irq));

   qep_enc_model u_enc (.mclk(mclk), .stepReq(stepReq),
      .stepDown(stepDown), .indexLevel(indexLevel), .encA(encA),
      .encB(encB), .encN(encN));

   task automatic wrap_up();
      $display("Mismatches %0d in %0d checks", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Handshakes judged at the falling edge, acted on at the next rise
   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge mclk);
      awaddr <= {idx, qep_pkg::ADDR_LSB};
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb) begin
         @(negedge mclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bready && bvalid;
         resp = bresp;
         @(posedge mclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
   endtask

   task automatic rd(input logic [5:0] idx);
      logic ta, tb;
      tb = 1'b0;
      @(posedge mclk);
      araddr <= {idx, qep_pkg::ADDR_LSB};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tb) begin
         @(negedge mclk);
         ta = arvalid && arready;
         tb = rready && rvalid;
         resp = rresp;
         val = rdata;
         @(posedge mclk);
         if (ta) arvalid <= 1'b0;
         if (tb) rready <= 1'b0;
      end
   endtask

   task automatic rc(input logic [5:0] idx, input logic [31:0] exp,
      input string what);
      rd(idx);
      chk(what, val, exp);
   endtask

   // Steps spaced wider than the input synchroniser
   task automatic move(input logic down, input int n);
      repeat (n) begin
         @(posedge mclk);
         stepReq <= 1'b1;
         stepDown <= down;
         @(posedge mclk);
         stepReq <= 1'b0;
         repeat (2) @(posedge mclk);
         ph = down ? ph + 3 : ph + 1;
      end
      repeat (6) @(posedge mclk);
   endtask

   task automatic index(input logic lvl);
      @(posedge mclk);
      indexLevel <= lvl;
      repeat (6) @(posedge mclk);
   endtask

   task automatic irqChk(input logic exp);
      @(negedge mclk);
      chk("irq", {31'h0, irq}, {31'h0, exp});
   endtask

   task automatic ramp(input logic [31:0] v);
      @(posedge mclk);
      rampActualPosition <= v;
      repeat (6) @(posedge mclk);
   endtask

   initial begin
      rstn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      {stepReq, stepDown, indexLevel} = 3'h0;
      rampActualPosition = 32'h0;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      rc(qep_pkg::IDX_CONFIG, 32'h0, "config");
      rc(qep_pkg::IDX_POSITION, 32'h0, "position");
      // Config zero: N low-active, level, idle A/B qualify
      rc(qep_pkg::IDX_FLAGS, 32'h1, "flags");
      rc(qep_pkg::IDX_LATCH, 32'h0, "latch");
      rc(qep_pkg::IDX_MASK, 32'h3, "mask");
      rc(qep_pkg::IDX_SCALE, 32'h0, "scale read");
      rc(qep_pkg::IDX_THRESH, 32'h0, "threshold read");
      rd(6'h10);
      chk("unmapped rresp", {30'h0, resp}, 32'h2);
      wr(6'h10, 32'h1);
      chk("unmapped bresp", {30'h0, resp}, 32'h2);
      wr(qep_pkg::IDX_LATCH, 32'h55);
      chk("latch bresp", {30'h0, resp}, 32'h0);
      rc(qep_pkg::IDX_LATCH, 32'h0, "latch read only");
      wr(qep_pkg::IDX_CONFIG, 32'hFFFF_FFFF);
      rc(qep_pkg::IDX_CONFIG, 32'h7FF, "config width");
      wr(qep_pkg::IDX_CONFIG, 32'h0);
      foreach (posv[i]) begin
         wr(qep_pkg::IDX_POSITION, posv[i]);
         rc(qep_pkg::IDX_POSITION, posv[i], "position rw");
      end
      wr(qep_pkg::IDX_POSITION, 32'h0);
      move(1'b0, 4);
      rc(qep_pkg::IDX_POSITION, 32'h4, "count up");
      move(1'b1, 2);
      rc(qep_pkg::IDX_POSITION, 32'h2, "count down");
      wr(qep_pkg::IDX_SCALE, 32'hFFFF_0000);
      move(1'b0, 1);
      rc(qep_pkg::IDX_POSITION, 32'h1, "negative scale");
      wr(qep_pkg::IDX_POSITION, 32'h0);
      wr(qep_pkg::IDX_SCALE, 32'h0000_8000);
      move(1'b0, 1);
      rc(qep_pkg::IDX_POSITION, 32'h0, "binary half");
      move(1'b0, 1);
      rc(qep_pkg::IDX_POSITION, 32'h1, "binary carry");
      wr(qep_pkg::IDX_CONFIG, 32'h400);
      wr(qep_pkg::IDX_POSITION, 32'h0);
      wr(qep_pkg::IDX_SCALE, 32'h0000_1388);
      move(1'b0, 2);
      rc(qep_pkg::IDX_POSITION, 32'h1, "decimal carry");
      wr(qep_pkg::IDX_SCALE, 32'h0001_0000);
      for (int s = 0; s < 4; s++) begin
         wr(qep_pkg::IDX_CONFIG, 32'h01C | 32'(s << 6));
         wr(qep_pkg::IDX_FLAGS, 32'h3);
         index(1'b1);
         irqChk(onRise[s]);
         rc(qep_pkg::IDX_FLAGS, {31'h0, onRise[s]}, "n rise");
         index(1'b0);
         rc(qep_pkg::IDX_FLAGS, {31'h0, onFall[s]}, "n fall");
      end
      rc(qep_pkg::IDX_LATCH, 32'h1, "latch only");
      wr(qep_pkg::IDX_POSITION, 32'h7);
      wr(qep_pkg::IDX_CONFIG, 32'h16C);
      index(1'b1);
      index(1'b0);
      rc(qep_pkg::IDX_LATCH, 32'h7, "latch once");
      rc(qep_pkg::IDX_POSITION, 32'h0, "clear once");
      wr(qep_pkg::IDX_POSITION, 32'h5);
      index(1'b1);
      index(1'b0);
      rc(qep_pkg::IDX_LATCH, 32'h7, "no second latch");
      rc(qep_pkg::IDX_POSITION, 32'h5, "no second clear");
      wr(qep_pkg::IDX_CONFIG, 32'h047);
      move(1'b0, (4 - ph % 4) % 4);
      wr(qep_pkg::IDX_FLAGS, 32'h3);
      index(1'b1);
      index(1'b0);
      rc(qep_pkg::IDX_FLAGS, 32'h0, "unqualified n");
      move(1'b0, 2);
      index(1'b1);
      index(1'b0);
      rc(qep_pkg::IDX_FLAGS, 32'h1, "qualified n");
      wr(qep_pkg::IDX_CONFIG, 32'h0);
      wr(qep_pkg::IDX_POSITION, 32'h0);
      ramp(32'h0010_0000);
      rc(qep_pkg::IDX_FLAGS, 32'h0, "drift off");
      // Gap brought to the limit before the threshold goes live
      ramp(32'h000F_FFFF);
      // Threshold keeps only 20 bits, so all ones means 0xFFFFF
      wr(qep_pkg::IDX_THRESH, 32'hFFFF_FFFF);
      rc(qep_pkg::IDX_FLAGS, 32'h0, "drift at limit");
      ramp(32'h0010_0000);
      irqChk(1'b1);
      wr(qep_pkg::IDX_FLAGS, 32'h2);
      rc(qep_pkg::IDX_FLAGS, 32'h2, "drift persists");
      wr(qep_pkg::IDX_MASK, 32'h0);
      irqChk(1'b0);
      wr(qep_pkg::IDX_MASK, 32'h3);
      ramp(32'h0);
      wr(qep_pkg::IDX_FLAGS, 32'h2);
      rc(qep_pkg::IDX_FLAGS, 32'h0, "drift cleared");
      irqChk(1'b0);
      wrap_up();
   end
endmodule
